// ---- common/bsd_params.svh ----
// Constants for the burner status display driver
`ifndef BSD_PARAMS_SVH
`define BSD_PARAMS_SVH

// Clock rate and timebase
`define BSD_CLK_HZ 50000000
`define BSD_TICK_TIME_MS 1

// Station address shown after power-up, in ms
`define BSD_ADDR_TIME_MS 10000

// Half period of every flashing lamp, in ms
`define BSD_FLASH_TIME_MS 250

// Dwell of each frame of a multi-frame code, in ms
`define BSD_FRAME_TIME_MS 1000

// Display format values for errors, trips and warnings; reset value is the 4-digit form
`define BSD_FMT_2DIGIT 1'b0
`define BSD_FMT_4DIGIT 1'b1
`define BSD_FMT_RESET `BSD_FMT_4DIGIT

// Frame counts of each presentation
`define BSD_FRAMES_ERR2 2'h2
`define BSD_FRAMES_WARN2 2'h1
`define BSD_FRAMES_ERR4 2'h3
`define BSD_FRAMES_IL4 2'h3
`define BSD_FRAMES_WARN4 2'h2

`endif

// ---- common/bsd_pkg.sv ----
// Types shared by the burner status display driver
package bsd_pkg;

	// Characters the two digits can show
	typedef enum logic [4:0] {
		CH_0 = 5'h00, CH_1 = 5'h01, CH_2 = 5'h02, CH_3 = 5'h03, CH_4 = 5'h04,
		CH_5 = 5'h05, CH_6 = 5'h06, CH_7 = 5'h07, CH_8 = 5'h08, CH_9 = 5'h09,
		CH_E = 5'h0A, CH_A = 5'h0B, CH_P = 5'h0C, CH_LO_O = 5'h0D, CH_F = 5'h0E,
		CH_R = 5'h0F, CH_UP_O = 5'h10, CH_I = 5'h11, CH_L = 5'h12, CH_BLANK = 5'h13
	} bsd_char_t;

	// Burner process phase from the sequencer
	typedef enum logic [2:0] {
		PH_STOP = 3'h0, PH_P1 = 3'h1, PH_P2 = 3'h2, PH_P3 = 3'h3,
		PH_P4 = 3'h4, PH_P5 = 3'h5, PH_P6 = 3'h6
	} bsd_phase_t;

	// Digit display source, highest priority first except MD_IL4, which outranks MD_ERR4
	typedef enum logic [2:0] {
		MD_ADDR = 3'h0, MD_ERR2 = 3'h1, MD_ERR4 = 3'h2, MD_IL4 = 3'h3,
		MD_WARN2 = 3'h4, MD_WARN4 = 3'h5, MD_STBY = 3'h6, MD_PROC = 3'h7
	} bsd_mode_t;

	// Lockout, warning and interlock trip report
	typedef struct packed {
		logic lockout;
		logic interlock;
		logic [3:0] il_input;
		logic [3:0] d2;
		logic [3:0] d1;
		logic [3:0] d0;
		logic warning;
		logic [3:0] w1;
		logic [3:0] w0;
	} bsd_fault_t;

	// Standby indications
	typedef struct packed {
		logic hitemp_end;
		logic flame_relay;
		logic comb_stby_set;
		logic comb_stby_closed;
		logic man_valve_set;
		logic man_valve_closed;
	} bsd_stby_t;

	// Discrete lamp sources
	typedef struct packed {
		logic startup;
		logic pilot_startup;
		logic setup_mode;
		logic test_run;
		logic writing;
		logic spark;
		logic pilot;
		logic main;
		logic flame;
		logic has_shutter;
		logic shutter_active;
		logic link_ok;
		logic il_normal;
		logic il_receiving;
		logic hitemp;
		logic [3:0] in_used;
		logic [3:0] in_shorted;
		logic [3:0] in_offdelay;
	} bsd_lamp_src_t;

	// Lamp outputs
	typedef struct packed {
		logic supply_lamp;
		logic run_lamp;
		logic test_write_lamp;
		logic lockout_lamp;
		logic spark_transformer_drive;
		logic pilot_valve_output;
		logic main_valve_output;
		logic detector_signal_lamp;
		logic shutter_lamp;
		logic link_lamp;
		logic interlock_lamp;
		logic hitemp_lamp;
		logic [3:0] input_lamp;
	} bsd_lamps_t;

	// Timebase state
	typedef struct packed {
		logic [15:0] pre_cnt;
		logic tick;
		logic [9:0] flash_cnt;
		logic flash;
		logic [9:0] frame_cnt;
		logic frame_step;
	} bsd_tb_state_t;

	// Main display state
	typedef struct packed {
		logic [13:0] addr_cnt;
		logic addr_done;
		bsd_mode_t mode;
		logic [1:0] frame;
		logic fmt4;
		logic lock_prev;
		logic post_reset;
		logic [6:0] seg_hi;
		logic [6:0] seg_lo;
		bsd_lamps_t lamps;
	} bsd_state_t;

endpackage

// ---- rtl/bsd_timebase.sv ----
// Shared prescaled timebase for flashing and frame stepping
`timescale 1ns/10ps
module bsd_timebase #(
	parameter int TICK_CYC = 50000,
	parameter int FLASH_TICKS = 250,
	parameter int FRAME_TICKS = 1000
) (
	// Clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Timing outputs
	output logic tick,
	output logic flash,
	output logic frame_step
);
	import bsd_pkg::*;

	bsd_tb_state_t s_q;
	bsd_tb_state_t s_d;

	// Prescaler to one tick, then flash toggle and frame pulse
	always_comb
	begin
		s_d = s_q;
		s_d.tick = 1'b0;
		s_d.frame_step = 1'b0;
		if (s_q.pre_cnt == 16'(TICK_CYC - 1))
		begin
			s_d.pre_cnt = 16'h0000;
			s_d.tick = 1'b1;
		end
		else
			s_d.pre_cnt = s_q.pre_cnt + 16'h0001;
		if (s_q.tick)
		begin
			if (s_q.flash_cnt == 10'(FLASH_TICKS - 1))
			begin
				s_d.flash_cnt = 10'h000;
				s_d.flash = ~s_q.flash;
			end
			else
				s_d.flash_cnt = s_q.flash_cnt + 10'h001;
			if (s_q.frame_cnt == 10'(FRAME_TICKS - 1))
			begin
				s_d.frame_cnt = 10'h000;
				s_d.frame_step = 1'b1;
			end
			else
				s_d.frame_cnt = s_q.frame_cnt + 10'h001;
		end
	end

	// State register, frozen while ce is low
	always_ff @(posedge clk)
	begin
		if (reset)
			s_q <= '0;
		else if (ce)
			s_q <= s_d;
	end

	assign tick = s_q.tick;
	assign flash = s_q.flash;
	assign frame_step = s_q.frame_step;

endmodule // bsd_timebase

// ---- rtl/bsd_glyph.sv ----
// Seven-segment pattern encoder for the two display digits
`timescale 1ns/10ps
module bsd_glyph (
	// Characters
	input bsd_pkg::bsd_char_t char_hi,
	input bsd_pkg::bsd_char_t char_lo,
	// Segment patterns, bit 6 is g and bit 0 is a, high lights
	output logic [6:0] seg_hi,
	output logic [6:0] seg_lo
);
	import bsd_pkg::*;

	// Pattern lookup for one character
	function automatic logic [6:0] glyph(input bsd_char_t c);
		unique case (c)
			CH_0: glyph = 7'h3F;
			CH_1: glyph = 7'h06;
			CH_2: glyph = 7'h5B;
			CH_3: glyph = 7'h4F;
			CH_4: glyph = 7'h66;
			CH_5: glyph = 7'h6D;
			CH_6: glyph = 7'h7D;
			CH_7: glyph = 7'h07;
			CH_8: glyph = 7'h7F;
			CH_9: glyph = 7'h6F;
			CH_E: glyph = 7'h79;
			CH_A: glyph = 7'h77;
			CH_P: glyph = 7'h73;
			CH_LO_O: glyph = 7'h5C;
			CH_F: glyph = 7'h71;
			CH_R: glyph = 7'h50;
			CH_UP_O: glyph = 7'h3F;
			CH_I: glyph = 7'h10;
			CH_L: glyph = 7'h38;
			CH_BLANK: glyph = 7'h00;
			default: glyph = 7'h00;
		endcase
	endfunction

	// Both digits
	assign seg_hi = glyph(char_hi);
	assign seg_lo = glyph(char_lo);

endmodule // bsd_glyph

// ---- rtl/bsd_top.sv ----
// Front-panel digit and lamp driver for a burner control module
`timescale 1ns/10ps
`include "bsd_params.svh"

// How it works
// - Station address shown for ten seconds after power-up
// - Phase shown as blank or P1 to P6
// - oF after high-temp end, Fr for relay
// - OP when combustion standby set and open
// - oo when manual valve set and closed
// - Error code shown, process returns after reset
// - Setting picks 2-digit or 4-digit format
// - 2-digit: E+digit alternates process; warning EA
// - 4-digit trip: iL, input number, process
// - 4-digit error: E+digit, two digits, process
// - 4-digit warning: EA then two digits
// - Run lamp on at startup, flashes setup
// - Test-write lamp on test run, flashes write
// - Test-write lamp flashes for whole write
// - Lockout lamp on, blinks after reset, off
// - Ignition, valve, flame lamps follow signals
// - Shutter lamp flashes if shutter fitted and active
// - Link lamp healthy; interlock lamp flashes receiving
// - High-temp lamp on during 760 mode
// - Input lamps off, on, or flashing
// - Format resets to 4-digit form
module bsd_top #(
	parameter int TICK_CYCLES = (`BSD_CLK_HZ / 1000) * `BSD_TICK_TIME_MS,
	parameter int ADDR_TICKS = `BSD_ADDR_TIME_MS / `BSD_TICK_TIME_MS,
	parameter int FLASH_TICKS = `BSD_FLASH_TIME_MS / `BSD_TICK_TIME_MS,
	parameter int FRAME_TICKS = `BSD_FRAME_TIME_MS / `BSD_TICK_TIME_MS
) (
	// Clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Configuration
	input wire logic [3:0] station_tens,
	input wire logic [3:0] station_ones,
	input wire logic fmt_write,
	input wire logic fmt_4digit,
	// Sequencer status
	input bsd_pkg::bsd_phase_t phase,
	input bsd_pkg::bsd_fault_t fault,
	input bsd_pkg::bsd_stby_t stby,
	input bsd_pkg::bsd_lamp_src_t lamp_src,
	// Display outputs
	output logic [6:0] seg_hi,
	output logic [6:0] seg_lo,
	output bsd_pkg::bsd_lamps_t lamps,
	output logic fmt_is_4digit,
	output logic addr_showing
);
	import bsd_pkg::*;

	// State and its next value
	bsd_state_t s_q;
	bsd_state_t s_d;
	// Timebase strobes
	logic tick;
	logic flash;
	logic frame_step;
	// Characters of the two digits, left one in the upper half
	logic [9:0] chars;
	bsd_char_t char_hi;
	bsd_char_t char_lo;
	// Segment patterns before the output register
	logic [6:0] glyph_hi;
	logic [6:0] glyph_lo;
	// Display source, its frame count and any standby code
	bsd_mode_t mode_sel;
	logic [1:0] frames;
	logic [10:0] stby_code;

	// Decimal digit to character, out of range blanks
	function automatic bsd_char_t digit_char(input logic [3:0] d);
		if (d > 4'h9)
			digit_char = CH_BLANK;
		else
			digit_char = bsd_char_t'({1'b0, d});
	endfunction

	// Process phase to its two characters
	function automatic logic [9:0] phase_chars(input bsd_phase_t p);
		if (p == PH_STOP)
			phase_chars = {CH_BLANK, CH_BLANK};
		else
			phase_chars = {CH_P, digit_char({1'b0, p})};
	endfunction

	// Standby code characters with a valid flag on top
	function automatic logic [10:0] stby_chars(input bsd_stby_t s);
		if (s.hitemp_end)
			stby_chars = {1'b1, CH_LO_O, CH_F};
		else if (s.flame_relay)
			stby_chars = {1'b1, CH_F, CH_R};
		else if (s.comb_stby_set && !s.comb_stby_closed)
			stby_chars = {1'b1, CH_UP_O, CH_P};
		else if (s.man_valve_set && s.man_valve_closed)
			stby_chars = {1'b1, CH_LO_O, CH_LO_O};
		else
			stby_chars = {1'b0, CH_BLANK, CH_BLANK};
	endfunction

	// Standby code of the present inputs
	assign stby_code = stby_chars(stby);

	// Shared flash and frame timebase
	bsd_timebase #(
		.TICK_CYC(TICK_CYCLES),
		.FLASH_TICKS(FLASH_TICKS),
		.FRAME_TICKS(FRAME_TICKS)
	) u_timebase (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.tick(tick),
		.flash(flash),
		.frame_step(frame_step)
	);

	// Segment encoding of the chosen characters
	bsd_glyph u_glyph (
		.char_hi(char_hi),
		.char_lo(char_lo),
		.seg_hi(glyph_hi),
		.seg_lo(glyph_lo)
	);

	// Digit source selection by fixed priority
	always_comb
	begin
		if (!s_q.addr_done)
			mode_sel = MD_ADDR;
		// Lockout takes the trip form only in 4-digit
		else if (fault.lockout && fault.interlock && s_q.fmt4)
			mode_sel = MD_IL4;
		else if (fault.lockout)
			mode_sel = s_q.fmt4 ? MD_ERR4 : MD_ERR2;
		// Warnings rank below lockout, above standby
		else if (fault.warning)
			mode_sel = s_q.fmt4 ? MD_WARN4 : MD_WARN2;
		else if (stby_code[10])
			mode_sel = MD_STBY;
		else
			mode_sel = MD_PROC;
	end

	// Number of frames of the current presentation
	always_comb
	begin
		unique case (s_q.mode)
			MD_ERR2: frames = `BSD_FRAMES_ERR2;
			MD_WARN2: frames = `BSD_FRAMES_WARN2;
			MD_ERR4: frames = `BSD_FRAMES_ERR4;
			MD_IL4: frames = `BSD_FRAMES_IL4;
			MD_WARN4: frames = `BSD_FRAMES_WARN4;
			// Address, standby and process hold one frame
			MD_ADDR, MD_STBY, MD_PROC: frames = 2'h1;
		endcase
	end

	// Characters for the current mode and frame
	always_comb
	begin
		// Last frame of error and trip codes keeps the process code
		chars = phase_chars(phase);
		unique case (s_q.mode)
			MD_ADDR:
				chars = {digit_char(station_tens), digit_char(station_ones)};
			MD_ERR2:
				if (s_q.frame == 2'h0)
					chars = {CH_E, digit_char(fault.d0)};
			MD_WARN2:
				chars = {CH_E, CH_A};
			MD_IL4:
				if (s_q.frame == 2'h0)
					chars = {CH_I, CH_L};
				else if (s_q.frame == 2'h1)
					chars = {CH_BLANK, digit_char(fault.il_input)};
			MD_ERR4:
				if (s_q.frame == 2'h0)
					chars = {CH_E, digit_char(fault.d2)};
				else if (s_q.frame == 2'h1)
					chars = {digit_char(fault.d1), digit_char(fault.d0)};
			MD_WARN4:
				if (s_q.frame == 2'h0)
					chars = {CH_E, CH_A};
				else
					chars = {digit_char(fault.w1), digit_char(fault.w0)};
			MD_STBY:
				chars = stby_code[9:0];
			MD_PROC:
				chars = phase_chars(phase);
		endcase
	end

	// Split into the two digit characters
	assign char_hi = bsd_char_t'(chars[9:5]);
	assign char_lo = bsd_char_t'(chars[4:0]);

	// Next state of display, format and lamps
	always_comb
	begin
		s_d = s_q;
		// Power-up address timer
		if (!s_q.addr_done && tick)
		begin
			if (s_q.addr_cnt == 14'(ADDR_TICKS - 1))
				s_d.addr_done = 1'b1;
			else
				s_d.addr_cnt = s_q.addr_cnt + 14'h0001;
		end
		// Format setting
		if (fmt_write)
			s_d.fmt4 = fmt_4digit;
		// Frame sequencing, restart on a new source
		s_d.mode = mode_sel;
		if (mode_sel != s_q.mode)
			s_d.frame = 2'h0;
		else if (frame_step)
		begin
			// Wrap after the last frame of the presentation
			if (s_q.frame + 2'h1 >= frames)
				s_d.frame = 2'h0;
			else
				s_d.frame = s_q.frame + 2'h1;
		end
		// Segments from the chosen characters
		s_d.seg_hi = glyph_hi;
		s_d.seg_lo = glyph_lo;
		// Lockout lamp after-reset tracking
		s_d.lock_prev = fault.lockout;
		if (s_q.lock_prev && !fault.lockout && (lamp_src.startup || lamp_src.pilot_startup))
			s_d.post_reset = 1'b1;
		else if (fault.lockout || !(lamp_src.startup || lamp_src.pilot_startup))
			s_d.post_reset = 1'b0;
		// Discrete lamps
		s_d.lamps.supply_lamp = 1'b1;
		s_d.lamps.run_lamp = lamp_src.startup | (lamp_src.setup_mode & flash);
		if (lamp_src.writing)
			s_d.lamps.test_write_lamp = flash;
		else
			s_d.lamps.test_write_lamp = lamp_src.test_run;
		// Lockout lamp
		if (fault.lockout)
			s_d.lamps.lockout_lamp = 1'b1;
		else
			s_d.lamps.lockout_lamp = s_q.post_reset & flash;
		// Lamps that follow their sources
		s_d.lamps.spark_transformer_drive = lamp_src.spark;
		s_d.lamps.pilot_valve_output = lamp_src.pilot;
		s_d.lamps.main_valve_output = lamp_src.main;
		s_d.lamps.detector_signal_lamp = lamp_src.flame;
		// Shutter, link and interlock lamps
		s_d.lamps.shutter_lamp = lamp_src.has_shutter & lamp_src.shutter_active & flash;
		s_d.lamps.link_lamp = lamp_src.link_ok;
		if (lamp_src.il_receiving)
			s_d.lamps.interlock_lamp = flash;
		else
			s_d.lamps.interlock_lamp = lamp_src.il_normal;
		// High-temperature mode lamp
		s_d.lamps.hitemp_lamp = lamp_src.hitemp;
		// Interlock input lamps
		for (int i = 0; i < 4; i++)
		begin
			if (!lamp_src.in_used[i])
				s_d.lamps.input_lamp[i] = 1'b0;
			else if (lamp_src.in_shorted[i] || lamp_src.in_offdelay[i])
				s_d.lamps.input_lamp[i] = 1'b1;
			else
				s_d.lamps.input_lamp[i] = flash;
		end
	end

	// State register, frozen while ce is low
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			// Address mode and 4-digit format after reset
			s_q <= '0;
			s_q.mode <= MD_ADDR;
			s_q.fmt4 <= `BSD_FMT_RESET;
		end
		else if (ce)
			s_q <= s_d;
	end

	// Outputs straight from the state register
	assign seg_hi = s_q.seg_hi;
	assign seg_lo = s_q.seg_lo;
	// Lamps and status
	assign lamps = s_q.lamps;
	assign fmt_is_4digit = s_q.fmt4;
	assign addr_showing = ~s_q.addr_done;

endmodule // bsd_top

// ---- tb/bsd_top_asserts.sv ----
// Port assertions for the burner status display driver
`timescale 1ns/10ps
module bsd_top_asserts #(
	parameter int TICK_CYCLES = 4,
	parameter int ADDR_TICKS = 5
) (
	// Clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Watched inputs
	input wire logic fmt_write,
	input wire logic fmt_4digit,
	input bsd_pkg::bsd_fault_t fault,
	input bsd_pkg::bsd_lamp_src_t lamp_src,
	// Watched outputs
	input bsd_pkg::bsd_lamps_t lamps,
	input wire logic fmt_is_4digit,
	input wire logic addr_showing
);
	import bsd_pkg::*;
	int n_addr;
	logic live_q;
	// Enabled cycles since reset, and whether the last edge was live
	always_ff @(posedge clk)
	begin
		live_q <= !reset && ce;
		n_addr <= reset ? 0 : n_addr + int'(ce);
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	AST_RST_FMT: assert property (disable iff (1'b0) reset |=> fmt_is_4digit)
		else $error("format not 4-digit after reset");
	AST_RST_ADDR: assert property (disable iff (1'b0) reset |=> addr_showing)
		else $error("address not shown after reset");
	AST_ADDR_TIME: assert property ($fell(addr_showing) |-> n_addr >= ADDR_TICKS * TICK_CYCLES - 2
		&& n_addr <= ADDR_TICKS * TICK_CYCLES + 6)
		else $error("address shown for wrong time");
	AST_FOLLOW: assert property (live_q |-> {lamps.spark_transformer_drive, lamps.pilot_valve_output,
		lamps.main_valve_output, lamps.detector_signal_lamp}
		== $past({lamp_src.spark, lamp_src.pilot, lamp_src.main, lamp_src.flame}))
		else $error("output lamps not following");
	AST_HOT_LINK: assert property (live_q |-> {lamps.hitemp_lamp, lamps.link_lamp}
		== $past({lamp_src.hitemp, lamp_src.link_ok}))
		else $error("hitemp or link lamp wrong");
	AST_FMT_LOAD: assert property (live_q && $past(fmt_write) |-> fmt_is_4digit == $past(fmt_4digit))
		else $error("format not loaded");
	AST_SHUT_OFF: assert property (live_q && !$past(lamp_src.has_shutter) |-> !lamps.shutter_lamp)
		else $error("shutter lamp lit without shutter");
	AST_IN_LAMP: assert property (live_q |-> (lamps.input_lamp & ~$past(lamp_src.in_used)) == 4'h0
		&& ($past(lamp_src.in_used & (lamp_src.in_shorted | lamp_src.in_offdelay)) & ~lamps.input_lamp) == 4'h0)
		else $error("input lamp wrong");
	AST_RUN_ON: assert property (live_q && $past(lamp_src.startup) |-> lamps.run_lamp)
		else $error("run lamp off at startup");
	AST_LOCK_ON: assert property (live_q && $past(fault.lockout) |-> lamps.lockout_lamp)
		else $error("lockout lamp off in lockout");
	AST_TW_ON: assert property (live_q && $past(lamp_src.test_run && !lamp_src.writing)
		|-> lamps.test_write_lamp)
		else $error("test-write lamp off in test run");
	// Main scenarios reached
	cover property ($fell(addr_showing));
	cover property ($fell(lamps.lockout_lamp) && lamp_src.startup);
	cover property ($fell(fmt_is_4digit));
endmodule // bsd_top_asserts

bind bsd_top bsd_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .ADDR_TICKS(ADDR_TICKS)) u_bsd_top_asserts (
	.clk(clk), .reset(reset), .ce(ce), .fmt_write(fmt_write), .fmt_4digit(fmt_4digit), .fault(fault),
	.lamp_src(lamp_src), .lamps(lamps), .fmt_is_4digit(fmt_is_4digit), .addr_showing(addr_showing));

// ---- tb/bsd_panel.sv ----
// Front-panel model reading segment patterns back as characters
`timescale 1ns/10ps
module bsd_panel (
	// Segment patterns from the driver
	input wire logic [6:0] seg_hi,
	input wire logic [6:0] seg_lo,
	// Characters seen, left digit in the upper byte
	output logic [15:0] shown
);
	// Pattern to character; anything unknown reads as ?
	function automatic logic [7:0] rd(input logic [6:0] s);
		case (s)
			7'h00: rd = " ";
			7'h3F: rd = "0";
			7'h06: rd = "1";
			7'h5B: rd = "2";
			7'h4F: rd = "3";
			7'h66: rd = "4";
			7'h6D: rd = "5";
			7'h7D: rd = "6";
			7'h79: rd = "E";
			7'h77: rd = "A";
			7'h73: rd = "P";
			7'h5C: rd = "o";
			7'h71: rd = "F";
			7'h50: rd = "r";
			7'h38: rd = "L";
			7'h10, 7'h04: rd = "i";
			default: rd = "?";
		endcase
	endfunction
	// Both digits as the operator reads them
	assign shown = {rd(seg_hi), rd(seg_lo)};
endmodule // bsd_panel

// ---- tb/bsd_top_test.sv ----
// Self-checking testbench of the burner status display driver
`timescale 1ns/10ps
module bsd_top_test;
	import bsd_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic [3:0] st_t = 4'h1;
	logic [3:0] st_o = 4'h2;
	logic fmt_write = 1'b0;
	logic fmt_4digit = 1'b1;
	bsd_phase_t phase = PH_STOP;
	bsd_fault_t fault = '0;
	bsd_stby_t stby = '0;
	bsd_lamp_src_t lamp_src = '0;
	logic [6:0] seg_hi;
	logic [6:0] seg_lo;
	bsd_lamps_t lamps;
	logic fmt_is_4digit;
	logic addr_showing;
	logic [15:0] shown;
	int n_fail = 0;
	int checks_done = 0;

	// Short counts so the address, flash and frame timing fit the run
	bsd_top #(.TICK_CYCLES(4), .ADDR_TICKS(5), .FLASH_TICKS(2), .FRAME_TICKS(3)) u_bsd_top (
		.clk(clk), .reset(reset), .ce(ce), .station_tens(st_t), .station_ones(st_o),
		.fmt_write(fmt_write), .fmt_4digit(fmt_4digit), .phase(phase), .fault(fault), .stby(stby),
		.lamp_src(lamp_src), .seg_hi(seg_hi), .seg_lo(seg_lo), .lamps(lamps),
		.fmt_is_4digit(fmt_is_4digit), .addr_showing(addr_showing));
	bsd_panel u_bsd_panel (.seg_hi(seg_hi), .seg_lo(seg_lo), .shown(shown));

	// Clock of 20 ns
	always #10 clk = ~clk;

	// Verdict and end of run
	task automatic end_sim();
		if (n_fail == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// One comparison
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask

	// Wait a bounded time for two characters
	task automatic show(input string what, input logic [15:0] exp);
		for (int i = 0; i < 80 && shown !== exp; i++)
			@(negedge clk);
		chk(what, exp, shown);
	endtask

	// Follow n frames in turn and the wrap back to the first
	task automatic frames(input string what, input logic [47:0] exp, input int n);
		logic [15:0] cur;
		show(what, exp[47:32]);
		for (int k = 1; k <= n; k++)
		begin
			cur = shown;
			for (int i = 0; i < 40 && shown === cur; i++)
				@(negedge clk);
			chk(what, exp[47 - 16 * (k % n) -: 16], shown);
		end
	endtask

	// Watch the lamps: which were ever lit, which ever dark
	task automatic lamp_chk(input string what, input logic [15:0] on, input logic [15:0] fl);
		logic [15:0] s1;
		logic [15:0] s0;
		s1 = '0;
		s0 = '0;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 40; i++)
		begin
			@(negedge clk);
			s1 |= lamps;
			s0 |= ~lamps;
		end
		chk({what, " lit"}, on | fl, s1);
		chk({what, " dark"}, ~on, s0);
	endtask

	// Address after power-up, then blank in stop
	task automatic t_addr();
		chk("fmt", 16'h1, 16'(fmt_is_4digit));
		show("addr", "12");
		repeat (12) @(negedge clk);
		chk("addr held", "12", shown);
		repeat (15) @(negedge clk);
		chk("addr end", 16'h0, 16'(addr_showing));
		show("stop", "  ");
	endtask

	// Phase codes and standby codes with their order
	task automatic t_proc();
		for (int p = 1; p < 7; p++)
		begin
			phase = bsd_phase_t'(p);
			show("phase", {"P", 8'h30 + 8'(p)});
		end
		phase = PH_P1;
		stby = 6'h30;
		show("hitemp end", "oF");
		stby = 6'h10;
		show("relay", "Fr");
		stby = 6'h08;
		show("comb open", "0P");
		stby = 6'h0F;
		show("man valve", "oo");
		stby = 6'h04;
		show("comb closed", "P1");
	endtask

	// 4-digit error, trip and warning frames, lockout lamp
	task automatic t_fmt4();
		lamp_src.startup = 1'b1;
		fault.lockout = 1'b1;
		fault.d2 = 4'h1;
		fault.d0 = 4'h1;
		frames("err4", {"E1", "01", "P1"}, 3);
		lamp_chk("lockout", 16'hD000, 16'h0);
		fault.interlock = 1'b1;
		fault.il_input = 4'h3;
		frames("trip4", {"iL", " 3", "P1"}, 3);
		fault = '0;
		show("after reset", "P1");
		lamp_chk("post reset", 16'hC000, 16'h1000);
		lamp_src.startup = 1'b0;
		lamp_chk("start off", 16'h8000, 16'h0);
		fault.warning = 1'b1;
		fault.w1 = 4'h4;
		fault.w0 = 4'h2;
		stby = 6'h20;
		frames("warn4", {"EA", "42", "  "}, 2);
		fault = '0;
		stby = '0;
	endtask

	// Switch to 2-digit form
	task automatic t_fmt2();
		fmt_4digit = 1'b0;
		fmt_write = 1'b1;
		@(negedge clk);
		fmt_write = 1'b0;
		@(negedge clk);
		chk("fmt2", 16'h0, 16'(fmt_is_4digit));
		fault.lockout = 1'b1;
		fault.d2 = 4'h1;
		fault.d0 = 4'h3;
		frames("err2", {"E3", "P1", "  "}, 2);
		fault = '0;
		fault.warning = 1'b1;
		fault.w0 = 4'h5;
		show("warn2", "EA");
		repeat (30) @(negedge clk);
		chk("warn2 fixed", "EA", shown);
		fault = '0;
		show("clear", "P1");
	endtask

	// Lamp sets: steady, flashing and dark
	task automatic t_lamps();
		lamp_src = {15'h4ABD, 4'hF, 4'h1, 4'h2};
		lamp_chk("lamps a", 16'hEA73, 16'h008C);
		lamp_src = {15'h1552, 4'h5, 4'h0, 4'h0};
		lamp_chk("lamps b", 16'h8500, 16'h6025);
		lamp_src = '0;
	endtask

	// Clock enable freezes the lamps; a second reset restores address and format
	task automatic t_hold();
		@(negedge clk);
		lamp_src.spark = 1'b1;
		ce = 1'b0;
		repeat (5) @(negedge clk);
		chk("ce hold", 16'h0, 16'(lamps.spark_transformer_drive));
		ce = 1'b1;
		repeat (2) @(negedge clk);
		chk("ce run", 16'h1, 16'(lamps.spark_transformer_drive));
		reset = 1'b1;
		repeat (3) @(negedge clk);
		chk("reset segs", "  ", shown);
		reset = 1'b0;
		@(negedge clk);
		chk("fmt again", 16'h1, 16'(fmt_is_4digit));
		chk("addr again", 16'h1, 16'(addr_showing));
		show("addr again", "12");
		lamp_src = '0;
	endtask

	// Main sequence
	initial
	begin
		repeat (6) @(negedge clk);
		reset = 1'b0;
		@(negedge clk);
		t_addr();
		t_proc();
		t_fmt4();
		t_fmt2();
		t_lamps();
		t_hold();
		end_sim();
	end

	// Watchdog far past the expected run length
	initial
	begin
		#1000000;
		n_fail++;
		end_sim();
	end
endmodule // bsd_top_test
